// ===== dacsp_sync.sv
package dacsp_pkg;
    // ***********************************************************
    // frame and code constants
    // ***********************************************************
    localparam int FRAME_BITS = 24;
    localparam int CODE_W = 16;
    localparam int SCLK_MAX_MHZ = 50;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_A_BIT = 16;
    localparam int ADDR_B_BIT = 19;
    localparam logic [4:0] CNT_FULL = 5'h18;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [3:0] CMD_WRITE = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
    localparam logic [3:0] CMD_REF = 4'h7;
    localparam logic [3:0] CMD_READBACK = 4'h9;
    // pin vector positions inside the synchroniser
    localparam int PIN_SCLK = 0;
    localparam int PIN_SYNC = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_LOAD = 3;
    localparam int PIN_RST = 4;
    localparam int PIN_RSEL = 5;
    localparam int PIN_SPAN = 6;
    localparam int PIN_COUNT = 7;
endpackage

`timescale 1ns/1ps
module dacsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pins
    input wire logic [W-1:0] pin_in,
    // synchronised level and its previous value
    output logic [W-1:0] lvl,
    output logic [W-1:0] lvl_prev
);
    logic [W-1:0] meta_r;
    logic [W-1:0] lvl_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '1;
            lvl_r <= '1;
            prev_r <= '1;
        end else begin
            meta_r <= pin_in;
            lvl_r <= meta_r;
            prev_r <= lvl_r;
        end
    end

    assign lvl = lvl_r;
    assign lvl_prev = prev_r;
endmodule // dacsp_sync

// ===== dacsp_top.sv
// Contract
// - shift data in on serial clock falls
// - capture one bit per clock after sync
// - input shift register is 24 bits
// - serial output changes on rising edges
// - serial output serves chain or readback
// - load strobe copies new input data
// - strobe works pulsed or held low
// - reset pin acts on falling edge
// - strobe ignored while reset pin low
// - reset loads zero or midscale code
// - power-up code follows level select
// - init waits for reset pin release
// - span times one or two by pin
// - internal reference enabled out of reset
`timescale 1ns/1ps
module dacsp_top
    import dacsp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic serial_clk,
    input wire logic frame_sync_n,
    input wire logic serial_in_line,
    output logic serial_out_line,
    // static and control pins
    input wire logic load_strobe_n,
    input wire logic dev_reset_n,
    input wire logic reset_level_select,
    input wire logic span_select,
    // converter side
    output logic [CODE_W-1:0] dac_a_code,
    output logic [CODE_W-1:0] dac_b_code,
    output logic span_x2,
    output logic ref_internal_en,
    output logic [FRAME_BITS-1:0] frame_word,
    output logic frame_valid
);
    // ***********************************************************
    // pin synchronisation
    // ***********************************************************
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] lvl;
    logic [PIN_COUNT-1:0] prev;

    // reset pin enters inverted: the flops' reset value then reads as held, so
    // nothing initialises or sees an edge before the real pin level is sampled
    assign pins = {span_select, reset_level_select, ~dev_reset_n, load_strobe_n,
                   serial_in_line, frame_sync_n, serial_clk};

    dacsp_sync #(.W(PIN_COUNT)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(pins),
        .lvl(lvl),
        .lvl_prev(prev)
    );

    logic sclk_fall;
    logic sclk_rise;
    logic sync_fall;
    logic sync_rise;
    logic load_fall;
    logic rst_fall;
    // the core clock must run well above the serial clock; 50 MHz link needs faster sampling
    assign sclk_fall = prev[PIN_SCLK] & ~lvl[PIN_SCLK];
    assign sclk_rise = ~prev[PIN_SCLK] & lvl[PIN_SCLK];
    assign sync_fall = prev[PIN_SYNC] & ~lvl[PIN_SYNC];
    assign sync_rise = ~prev[PIN_SYNC] & lvl[PIN_SYNC];
    assign load_fall = prev[PIN_LOAD] & ~lvl[PIN_LOAD];
    assign rst_fall = ~prev[PIN_RST] & lvl[PIN_RST];

    function automatic logic [CODE_W-1:0] reset_code(input logic sel);
        return sel ? CODE_MID : CODE_ZERO;
    endfunction

    // ***********************************************************
    // state
    // ***********************************************************
    typedef enum logic [0:0] {DACSP_IDLE, DACSP_SHIFT} dacsp_frame_e;

    dacsp_frame_e state_r, state_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic sdo_r, sdo_nxt;
    logic [CODE_W-1:0] in_a_r, in_a_nxt, in_b_r, in_b_nxt;
    logic [CODE_W-1:0] dac_a_r, dac_a_nxt, dac_b_r, dac_b_nxt;
    logic new_a_r, new_a_nxt, new_b_r, new_b_nxt;
    logic init_done_r, init_done_nxt;
    logic span_r, span_nxt;
    logic ref_r, ref_nxt;
    logic [FRAME_BITS-1:0] word_r, word_nxt;
    logic valid_r, valid_nxt;

    always_comb begin
        logic [3:0] cmd;
        logic sel_a;
        logic sel_b;
        logic load_ok;
        logic wr;
        logic upd;
        cmd = shift_r[CMD_MSB:CMD_LSB];
        sel_a = shift_r[ADDR_A_BIT];
        sel_b = shift_r[ADDR_B_BIT];
        wr = 1'b0;
        upd = 1'b0;
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        sdo_nxt = sdo_r;
        in_a_nxt = in_a_r;
        in_b_nxt = in_b_r;
        dac_a_nxt = dac_a_r;
        dac_b_nxt = dac_b_r;
        new_a_nxt = new_a_r;
        new_b_nxt = new_b_r;
        init_done_nxt = init_done_r;
        ref_nxt = ref_r;
        word_nxt = word_r;
        valid_nxt = 1'b0;
        span_nxt = lvl[PIN_SPAN];
        // strobe gated by reset pin level
        load_ok = ~lvl[PIN_RST] & init_done_r;

        // ---- serial frame ----
        unique case (state_r)
            DACSP_IDLE: begin
                if (sync_fall) begin
                    state_nxt = DACSP_SHIFT;
                    cnt_nxt = 5'h00;
                end
            end
            DACSP_SHIFT: begin
                // one bit per clock, 24 clocks
                if (sclk_fall && cnt_r != CNT_FULL) begin
                    shift_nxt = {shift_r[FRAME_BITS-2:0], lvl[PIN_SDI]};
                    cnt_nxt = cnt_r + 5'h01;
                end
                // msb out feeds chain or readback
                if (sclk_rise) begin
                    sdo_nxt = shift_r[FRAME_BITS-1];
                end
                if (sync_rise) begin
                    state_nxt = DACSP_IDLE;
                    if (cnt_r == CNT_FULL) begin
                        word_nxt = shift_r;
                        valid_nxt = 1'b1;
                        wr = (cmd == CMD_WRITE) || (cmd == CMD_WRITE_UPD);
                        upd = (cmd == CMD_UPDATE) || (cmd == CMD_WRITE_UPD);
                        if (cmd == CMD_REF) begin
                            ref_nxt = ~shift_r[0];
                        end
                        if (cmd == CMD_READBACK) begin
                            shift_nxt = {8'h00, sel_b ? in_b_r : in_a_r};
                            // first readback bit must stand before the first fall
                            sdo_nxt = shift_nxt[FRAME_BITS-1];
                        end
                    end
                end
            end
        endcase

        // edge pulse or level held low after a write
        if (load_ok && (load_fall || (!lvl[PIN_LOAD] && wr)) || upd) begin
            if (new_a_r || (wr && sel_a) || (upd && sel_a)) begin
                dac_a_nxt = (wr && sel_a) ? shift_r[CODE_W-1:0] : in_a_r;
                new_a_nxt = 1'b0;
            end
            if (new_b_r || (wr && sel_b) || (upd && sel_b)) begin
                dac_b_nxt = (wr && sel_b) ? shift_r[CODE_W-1:0] : in_b_r;
                new_b_nxt = 1'b0;
            end
        end
        // a write in the same cycle as an update keeps its data flag unless consumed
        if (wr && sel_a) begin
            in_a_nxt = shift_r[CODE_W-1:0];
            if (!(load_ok && (load_fall || !lvl[PIN_LOAD])) && !upd) begin
                new_a_nxt = 1'b1;
            end
        end
        if (wr && sel_b) begin
            in_b_nxt = shift_r[CODE_W-1:0];
            if (!(load_ok && (load_fall || !lvl[PIN_LOAD])) && !upd) begin
                new_b_nxt = 1'b1;
            end
        end

        // held off until reset pin high
        if (!init_done_r && !lvl[PIN_RST]) begin
            init_done_nxt = 1'b1;
            in_a_nxt = reset_code(lvl[PIN_RSEL]);
            in_b_nxt = reset_code(lvl[PIN_RSEL]);
            dac_a_nxt = reset_code(lvl[PIN_RSEL]);
            dac_b_nxt = reset_code(lvl[PIN_RSEL]);
            new_a_nxt = 1'b0;
            new_b_nxt = 1'b0;
        end
        if (rst_fall) begin
            in_a_nxt = reset_code(lvl[PIN_RSEL]);
            in_b_nxt = reset_code(lvl[PIN_RSEL]);
            dac_a_nxt = reset_code(lvl[PIN_RSEL]);
            dac_b_nxt = reset_code(lvl[PIN_RSEL]);
            new_a_nxt = 1'b0;
            new_b_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= DACSP_IDLE;
            shift_r <= '0;
            cnt_r <= 5'h00;
            sdo_r <= 1'b0;
            in_a_r <= CODE_ZERO;
            in_b_r <= CODE_ZERO;
            dac_a_r <= CODE_ZERO;
            dac_b_r <= CODE_ZERO;
            new_a_r <= 1'b0;
            new_b_r <= 1'b0;
            init_done_r <= 1'b0;
            span_r <= 1'b0;
            ref_r <= 1'b1;
            word_r <= '0;
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            sdo_r <= sdo_nxt;
            in_a_r <= in_a_nxt;
            in_b_r <= in_b_nxt;
            dac_a_r <= dac_a_nxt;
            dac_b_r <= dac_b_nxt;
            new_a_r <= new_a_nxt;
            new_b_r <= new_b_nxt;
            init_done_r <= init_done_nxt;
            span_r <= span_nxt;
            ref_r <= ref_nxt;
            word_r <= word_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign serial_out_line = sdo_r;
    assign dac_a_code = dac_a_r;
    assign dac_b_code = dac_b_r;
    assign span_x2 = span_r;
    assign ref_internal_en = ref_r;
    assign frame_word = word_r;
    assign frame_valid = valid_r;
endmodule // dacsp_top

// ===== dacsp_checker.sv
`timescale 1ns/1ps
// ****
// pin level checks
// ****
module dacsp_checker
    import dacsp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pins
    input wire logic serial_clk,
    input wire logic frame_sync_n,
    input wire logic serial_out_line,
    input wire logic dev_reset_n,
    input wire logic reset_level_select,
    input wire logic span_select,
    // converter side
    input wire logic [CODE_W-1:0] dac_a_code,
    input wire logic [CODE_W-1:0] dac_b_code,
    input wire logic span_x2,
    input wire logic ref_internal_en,
    input wire logic [FRAME_BITS-1:0] frame_word,
    input wire logic frame_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_dev_fall;
        $fell(dev_reset_n);
    endsequence
    sequence s_codes_reset;
        ##[2:6] (dac_a_code == (reset_level_select ? CODE_MID : CODE_ZERO))
            && (dac_b_code == (reset_level_select ? CODE_MID : CODE_ZERO));
    endsequence
    valid_pulse_a: assert property (frame_valid |=> !frame_valid)
        else $error("frame valid longer than one cycle");
    valid_after_a: assert property (frame_valid |-> frame_sync_n && !$past(frame_sync_n, 8))
        else $error("frame valid without a closed frame");
    word_hold_a: assert property ($changed(frame_word) |-> frame_valid)
        else $error("frame word changed without valid");
    out_edge_a: assert property ($changed(serial_out_line) |-> $past(serial_clk, 2))
        else $error("serial out changed away from a clock rise");
    span_follow_a: assert property ($stable(span_select)[*6] |-> span_x2 == span_select)
        else $error("span flag does not follow span select");
    ref_reset_a: assert property ($rose(rst_n) |-> ref_internal_en)
        else $error("internal reference off out of reset");
    ref_fall_a: assert property ($fell(ref_internal_en) |-> frame_valid || $past(frame_valid))
        else $error("reference disabled without a frame");
    strobe_block_a: assert property ((!dev_reset_n)[*8] |-> $stable({dac_a_code, dac_b_code}))
        else $error("dac codes moved while reset pin low");
    reset_code_a: assert property (s_dev_fall |-> s_codes_reset)
        else $error("reset pin did not load reset code");
endmodule // dacsp_checker

// ===== dacsp_host.sv
`timescale 1ns/1ps
// ****
// host end of the serial link
// ****
module dacsp_host (
    // link pins
    output logic serial_clk,
    output logic frame_sync_n,
    output logic serial_in_line,
    input wire logic serial_out_line
);
    initial begin
        serial_clk = 1'b1;
        frame_sync_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // n clocks, msb first, read on falls
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        frame_sync_n = 1'b0;
        #160;
        for (int i = 0; i < n; i++) begin
            serial_in_line = w[23-i];
            #160 serial_clk = 1'b0;
            rd = {rd[22:0], serial_out_line};
            #160 serial_clk = 1'b1;
        end
        #160 frame_sync_n = 1'b1;
        // released line must not look like held data
        serial_in_line = ~serial_in_line;
        #320;
    endtask
endmodule // dacsp_host

// ===== dacsp_bench.sv
`timescale 1ns/1ps
// ****
// serial port bench
// ****
module dacsp_bench
    import dacsp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_strobe_n = 1'b1;
    logic dev_reset_n = 1'b0;
    logic reset_level_select = 1'b1;
    logic span_select = 1'b0;
    logic serial_clk, frame_sync_n, serial_in_line, serial_out_line;
    logic [CODE_W-1:0] dac_a_code, dac_b_code;
    logic span_x2, ref_internal_en, frame_valid;
    logic [FRAME_BITS-1:0] frame_word, rd;
    int fail_count = 0;
    int compares = 0;
    int nvalid = 0;
    int cyc = 0;
    dacsp_top DUT (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .serial_clk(serial_clk),
        .frame_sync_n(frame_sync_n),
        .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line),
        .load_strobe_n(load_strobe_n),
        .dev_reset_n(dev_reset_n),
        .reset_level_select(reset_level_select),
        .span_select(span_select),
        .dac_a_code(dac_a_code),
        .dac_b_code(dac_b_code),
        .span_x2(span_x2),
        .ref_internal_en(ref_internal_en),
        .frame_word(frame_word),
        .frame_valid(frame_valid)
    );
    dacsp_host host (
        .serial_clk(serial_clk),
        .frame_sync_n(frame_sync_n),
        .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line)
    );
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // ceiling well above the ~2550 cycles used
    always @(posedge core_clk) begin
        cyc++;
        if (frame_valid === 1'b1) nvalid++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [23:0] w, input int n);
        @(negedge core_clk);
        host.xfer(w, n, rd);
    endtask
    task automatic strobe();
        wt(1);
        load_strobe_n = 1'b0;
        wt(3);
        load_strobe_n = 1'b1;
        wt(6);
    endtask
    task automatic t_power();
        wt(10);
        chk("dac_a", 24'h000000, dac_a_code);
        chk("ref", 24'h000001, ref_internal_en);
        dev_reset_n = 1'b1;
        wt(8);
        chk("dac_a", CODE_MID, dac_a_code);
        chk("dac_b", CODE_MID, dac_b_code);
        $display("power_up done");
    endtask
    task automatic t_write();
        int n0;
        n0 = nvalid;
        send({CMD_WRITE, 4'h1, 16'h1234}, 24);
        chk("word", {CMD_WRITE, 4'h1, 16'h1234}, frame_word);
        chk("valids", 24'h000001, 24'(nvalid - n0));
        chk("dac_a", CODE_MID, dac_a_code);
        send({CMD_WRITE, 4'h8, 16'hBEEF}, 24);
        chk("chain", {CMD_WRITE, 4'h1, 16'h1234}, rd);
        strobe();
        chk("dac_a", 24'h001234, dac_a_code);
        chk("dac_b", 24'h00BEEF, dac_b_code);
        n0 = nvalid;
        send({CMD_WRITE_UPD, 4'h1, 16'h0F0F}, 20);
        chk("valids", 24'h000000, 24'(nvalid - n0));
        chk("dac_a", 24'h001234, dac_a_code);
        $display("write done");
    endtask
    task automatic t_readback();
        send({CMD_READBACK, 4'h1, 16'h0000}, 24);
        send(24'h000000, 24);
        chk("readback", 24'h001234, rd);
        load_strobe_n = 1'b0;
        send({CMD_WRITE, 4'h8, 16'h5A5A}, 24);
        chk("dac_b", 24'h005A5A, dac_b_code);
        chk("word", {CMD_WRITE, 4'h8, 16'h5A5A}, frame_word);
        load_strobe_n = 1'b1;
        send({CMD_WRITE, 4'h1, 16'hA5A5}, 24);
        chk("dac_a", 24'h001234, dac_a_code);
        send({CMD_UPDATE, 4'h1, 16'h0000}, 24);
        chk("dac_a", 24'h00A5A5, dac_a_code);
        send({CMD_WRITE_UPD, 4'h1, 16'h0F0F}, 24);
        chk("dac_a", 24'h000F0F, dac_a_code);
        $display("readback done");
    endtask
    task automatic t_dev_reset();
        reset_level_select = 1'b0;
        wt(4);
        dev_reset_n = 1'b0;
        wt(8);
        chk("dac_a", CODE_ZERO, dac_a_code);
        chk("dac_b", CODE_ZERO, dac_b_code);
        send({CMD_WRITE, 4'h1, 16'h7777}, 24);
        strobe();
        chk("dac_a", CODE_ZERO, dac_a_code);
        dev_reset_n = 1'b1;
        wt(8);
        $display("dev_reset done");
    endtask
    task automatic t_static();
        span_select = 1'b1;
        wt(8);
        chk("span", 24'h000001, span_x2);
        span_select = 1'b0;
        wt(8);
        chk("span", 24'h000000, span_x2);
        send({CMD_REF, 4'h0, 16'h0001}, 24);
        chk("ref", 24'h000000, ref_internal_en);
        send({CMD_REF, 4'h0, 16'h0000}, 24);
        chk("ref", 24'h000001, ref_internal_en);
        $display("static done");
    endtask
    initial begin
        wt(3);
        rst_n = 1'b1;
        t_power();
        t_write();
        t_readback();
        t_dev_reset();
        t_static();
        finish_test();
    end
endmodule // dacsp_bench

bind dacsp_top dacsp_checker chk_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .frame_sync_n(frame_sync_n),
    .serial_out_line(serial_out_line),
    .dev_reset_n(dev_reset_n),
    .reset_level_select(reset_level_select),
    .span_select(span_select),
    .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code),
    .span_x2(span_x2),
    .ref_internal_en(ref_internal_en),
    .frame_word(frame_word),
    .frame_valid(frame_valid)
);
